// >>> pkg/ubce_defines.vh
// Purpose: Offsets, field positions, reset values and counts for the baud and character engine
// Assumes: 32-bit register words, byte addresses
// Notes: Included by both design files
`ifndef UBCE_DEFINES_VH
`define UBCE_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define UBCE_CTRL_OFS 8'h00
`define UBCE_MODE_OFS 8'h04
`define UBCE_THR_OFS 8'h1C
`define UBCE_BRGR_OFS 8'h20
`define UBCE_FIDI_OFS 8'h40
`define UBCE_CSR_OFS 8'h14
`define UBCE_RHR_OFS 8'h18

// ----------------------------------------------------------------
// Control command bits
// ----------------------------------------------------------------
`define UBCE_CR_RST_RX 2
`define UBCE_CR_RST_TX 3
`define UBCE_CR_RX_EN 4
`define UBCE_CR_RX_DIS 5
`define UBCE_CR_TX_EN 6
`define UBCE_CR_TX_DIS 7

// ----------------------------------------------------------------
// Mode field positions
// ----------------------------------------------------------------
`define UBCE_MR_SPI_LO 0
`define UBCE_MR_SRC_LO 4
`define UBCE_MR_LEN_LO 6
`define UBCE_MR_SYNC 8
`define UBCE_MR_PAR_LO 9
`define UBCE_MR_STOP_LO 12
`define UBCE_MR_MSB 16
`define UBCE_MR_NINE 17
`define UBCE_MR_CKO 18
`define UBCE_MR_OVER 19
`define UBCE_MR_ISO 20

// ----------------------------------------------------------------
// Status bits, reset values, counts
// ----------------------------------------------------------------
`define UBCE_SR_RXRDY 0
`define UBCE_SR_HOLD 1
`define UBCE_SR_DONE 9
`define UBCE_FIDI_RST 11'h174
`define UBCE_PRESCALE 4'h8
`define UBCE_SYNC_MASTER_MIN 16'h0003
`define UBCE_SPI_MASTER_MIN 16'h0006
`define UBCE_START_16 4'h7
`define UBCE_START_8 4'h3

`endif

// >>> hw/ubce_baud_gen.v
// Purpose: Baud rate generator with clock divisor and card ratio divider
// Assumes: One clock domain, external clock already synchronised
// Notes: Emits one-cycle ticks rather than real clocks
`timescale 1ns/1ps
`include "ubce_defines.vh"

module ubce_baud_gen (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // Configuration
  input wire [1:0] i_src_sel,
  input wire [15:0] i_clock_divisor,
  input wire [10:0] i_card_ratio,
  input wire i_sync_mode,
  input wire i_iso_mode,
  input wire i_spi_mode,
  input wire i_cko,
  input wire i_over,
  // Synchronised serial clock pin level
  input wire i_sck_in,
  // Ticks
  output reg o_sample_tick,
  output reg o_bit_rise,
  output reg o_bit_fall,
  output reg o_sck_level
);

  reg [3:0] pre_cnt;
  reg sck_prev;
  reg [15:0] div_cnt;
  reg half_phase;
  reg [10:0] card_cnt;
  reg [3:0] ovs_cnt;
  reg src_tick;
  reg div_tick;
  reg div_rise;
  reg [15:0] eff_div;

  // ----------------------------------------------------------------
  // Source select: master clock, prescaled, or external pin edges
  // ----------------------------------------------------------------
  always @* begin
    case (i_src_sel)
      2'h0: src_tick = 1'b1;
      2'h1: src_tick = (pre_cnt == (`UBCE_PRESCALE - 4'h1));
      default: src_tick = i_sck_in & ~sck_prev;
    endcase
  end

  // Master-mode limit so the receive side can keep up
  always @* begin
    eff_div = i_clock_divisor;
    if (i_sync_mode && i_cko && !i_src_sel[1] && i_clock_divisor != 16'h0000) begin
      if (i_spi_mode && i_clock_divisor < `UBCE_SPI_MASTER_MIN)
        eff_div = `UBCE_SPI_MASTER_MIN;
      else if (!i_spi_mode && i_clock_divisor < `UBCE_SYNC_MASTER_MIN)
        eff_div = `UBCE_SYNC_MASTER_MIN;
    end
  end

  // Integer divider on the source tick; odd divisors on master clock give one more high cycle than low
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      pre_cnt <= 4'h0;
      sck_prev <= 1'b0;
      div_cnt <= 16'h0000;
      half_phase <= 1'b0;
      div_tick <= 1'b0;
      div_rise <= 1'b0;
    end else begin
      sck_prev <= i_sck_in;
      pre_cnt <= (pre_cnt == (`UBCE_PRESCALE - 4'h1)) ? 4'h0 : pre_cnt + 4'h1;
      div_tick <= 1'b0;
      div_rise <= 1'b0;
      if (eff_div == 16'h0000) begin
        div_cnt <= 16'h0000;
        half_phase <= 1'b0;
      end else if (src_tick) begin
        if (div_cnt + 16'h0001 >= eff_div) begin
          div_cnt <= 16'h0000;
          div_tick <= 1'b1;
          div_rise <= 1'b1;
          half_phase <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 16'h0001;
          // Half point: (div+1)/2 for master clock, so odd divisors stay high one cycle longer than low
          if (div_cnt + 16'h0001 == ((i_src_sel == 2'h0) ?
              ((eff_div + 16'h0001) >> 1) : (eff_div >> 1)))
            half_phase <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output ticks by mode
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      card_cnt <= 11'h000;
      ovs_cnt <= 4'h0;
      o_sample_tick <= 1'b0;
      o_bit_rise <= 1'b0;
      o_bit_fall <= 1'b0;
      o_sck_level <= 1'b0;
    end else begin
      o_sample_tick <= 1'b0;
      o_bit_rise <= 1'b0;
      o_bit_fall <= 1'b0;
      o_sck_level <= half_phase;
      if (i_sync_mode && i_src_sel == 2'h3) begin
        // Bit clock straight from the pin, divisor ignored
        o_bit_rise <= i_sck_in & ~sck_prev;
        o_bit_fall <= ~i_sck_in & sck_prev;
        o_sck_level <= i_sck_in;
      end else if (i_iso_mode) begin
        if (div_tick) begin
          if (card_cnt + 11'h001 >= i_card_ratio) begin
            card_cnt <= 11'h000;
            o_bit_fall <= 1'b1;
          end else begin
            card_cnt <= card_cnt + 11'h001;
            if (card_cnt + 11'h001 == (i_card_ratio >> 1))
              o_bit_rise <= 1'b1;
          end
        end
      end else if (i_sync_mode) begin
        o_bit_rise <= div_rise;
        o_bit_fall <= half_phase & (eff_div == 16'h0001 ? div_tick :
          (src_tick && div_cnt + 16'h0001 == ((i_src_sel == 2'h0) ?
          ((eff_div + 16'h0001) >> 1) : (eff_div >> 1))));
      end else if (div_tick) begin
        o_sample_tick <= 1'b1;
        ovs_cnt <= ovs_cnt + 4'h1;
        if (ovs_cnt == (i_over ? 4'h7 : 4'hF)) begin
          ovs_cnt <= 4'h0;
          o_bit_fall <= 1'b1;
        end
      end
    end
  end

endmodule

// >>> hw/ubce_top.v
// Purpose: Baud generation, transmitter and asynchronous receiver of a serial channel
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: Parity checking, timeguard and fractional divisor are not handled here
// What this block does
// - Synchronous baud clock is source divided by clock divisor, no oversampling.
// - Synchronous with source select 3 takes bit clock straight from pin.
// - Master synchronous clock limited to master clock over 3, SPI over 6.
// - Undivided master clock source gives 50:50 duty for even divisors; odd ones run one cycle longer high.
// - Card mode drives divided clock on serial clock pin when enabled.
// - Card bit time is card clock divided by card ratio, up to 2047.
// - Card ratio field resets to 0x174, 372 decimal.
// - Receiver and transmitter disabled after reset until enabled; config writable.
// - Soft resets stop communication at once, clear flags, keep configuration.
// - Receiver disable during a character waits for that character's end.
// - Transmitter disable waits for shifter and holding register to drain.
// - Transmit start, up to nine data, optional parity, stop bits on falling edges.
// - Length from length field, nine-bit select forces nine bits.
// - Bit order select 1 sends MSB first, 0 LSB first.
// - Stop count follows stop field; the 1.5 setting sends two stop bits, as no bit rise comes in asynchronous mode.
// - Finished character loads holding char into shifter, raising holding-empty flag.
// - Both flags low while disabled; writes while holding not empty dropped.
// - Asynchronous receiver oversamples at 16x, or 8x with oversampling select.
// - Start at eighth low sample at 16x, fourth at 8x, then per period.
// - Receiver waits one stop bit without checking its level, then hunts for next start at once.
// - Divisor 0 stops the baud generator; divisor 1 bypasses it.
// - Asynchronous divided clock samples receiver, then divided by 16 or 8.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "ubce_defines.vh"

module ubce_top (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // Register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // Serial pins
  input wire i_rxd,
  output reg o_txd,
  input wire i_sck,
  output reg o_sck,
  output reg o_sck_oe
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  localparam TX_IDLE = 5'b00001;
  localparam TX_START = 5'b00010;
  localparam TX_DATA = 5'b00100;
  localparam TX_PAR = 5'b01000;
  localparam TX_STOP = 5'b10000;
  localparam RX_HUNT = 4'b0001;
  localparam RX_DATA = 4'b0010;
  localparam RX_PAR = 4'b0100;
  localparam RX_STOP = 4'b1000;

  reg [31:0] mode_register;
  reg [15:0] clock_divisor;
  reg [10:0] card_sampling_ratio;
  reg rx_sync1, rx_sync2, sck_sync1, sck_sync2;
  reg tx_on, rx_on, tx_dis_pend, rx_dis_pend;
  reg [8:0] hold_data;
  reg hold_full;
  reg [8:0] shift;
  reg [4:0] tx_state;
  reg [3:0] tx_cnt;
  reg tx_par;
  reg [1:0] stop_half;
  reg [3:0] rx_state;
  reg [3:0] rx_cnt;
  reg [3:0] rx_ovs;
  reg [8:0] rx_shift;
  reg [8:0] rx_data;
  reg rx_ready;
  wire sample_tick, bit_rise, bit_fall, sck_level;
  wire [3:0] char_len;
  wire [2:0] par_kind;
  wire [1:0] stop_cnt;
  wire async_mode;
  wire wr_ctrl;
  wire tx_busy;

  assign char_len = mode_register[`UBCE_MR_NINE] ? 4'h9 :
    (4'h5 + {2'b00, mode_register[`UBCE_MR_LEN_LO +: 2]});
  assign par_kind = mode_register[`UBCE_MR_PAR_LO +: 3];
  assign stop_cnt = mode_register[`UBCE_MR_STOP_LO +: 2];
  assign async_mode = ~mode_register[`UBCE_MR_SYNC] & ~mode_register[`UBCE_MR_ISO];
  assign wr_ctrl = i_wr && (i_addr == `UBCE_CTRL_OFS);
  assign tx_busy = (tx_state != TX_IDLE);

  // Two-flop synchronisers for pin inputs
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      rx_sync1 <= 1'b1;
      rx_sync2 <= 1'b1;
      sck_sync1 <= 1'b0;
      sck_sync2 <= 1'b0;
    end else begin
      rx_sync1 <= i_rxd;
      rx_sync2 <= rx_sync1;
      sck_sync1 <= i_sck;
      sck_sync2 <= sck_sync1;
    end
  end

  ubce_baud_gen u_baud (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_src_sel(mode_register[`UBCE_MR_SRC_LO +: 2]),
    .i_clock_divisor(clock_divisor),
    .i_card_ratio(card_sampling_ratio),
    .i_sync_mode(mode_register[`UBCE_MR_SYNC]),
    .i_iso_mode(mode_register[`UBCE_MR_ISO]),
    .i_spi_mode(mode_register[`UBCE_MR_SPI_LO]),
    .i_cko(mode_register[`UBCE_MR_CKO]),
    .i_over(mode_register[`UBCE_MR_OVER]),
    .i_sck_in(sck_sync2),
    .o_sample_tick(sample_tick),
    .o_bit_rise(bit_rise),
    .o_bit_fall(bit_fall),
    .o_sck_level(sck_level)
  );

  // ----------------------------------------------------------------
  // Configuration registers, writable while channel disabled
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      mode_register <= 32'h00000000;
      clock_divisor <= 16'h0000;
      card_sampling_ratio <= `UBCE_FIDI_RST;
    end else if (i_wr) begin
      if (i_addr == `UBCE_MODE_OFS)
        mode_register <= i_wdata;
      if (i_addr == `UBCE_BRGR_OFS)
        clock_divisor <= i_wdata[15:0];
      if (i_addr == `UBCE_FIDI_OFS)
        card_sampling_ratio <= i_wdata[10:0];
    end
  end

  // Serial clock pin drive, card clock or master bit clock
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_sck <= 1'b0;
      o_sck_oe <= 1'b0;
    end else begin
      o_sck <= sck_level;
      o_sck_oe <= mode_register[`UBCE_MR_CKO] & (mode_register[`UBCE_MR_SRC_LO +: 2] != 2'h3);
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // Enable, disable and soft reset; disable deferred until fully drained
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      tx_on <= 1'b0;
      tx_dis_pend <= 1'b0;
      hold_full <= 1'b0;
      hold_data <= 9'h000;
      tx_state <= TX_IDLE;
      tx_cnt <= 4'h0;
      shift <= 9'h000;
      tx_par <= 1'b0;
      stop_half <= 2'h0;
      o_txd <= 1'b1;
    end else if (wr_ctrl && i_wdata[`UBCE_CR_RST_TX]) begin
      tx_on <= 1'b0;
      tx_dis_pend <= 1'b0;
      hold_full <= 1'b0;
      tx_state <= TX_IDLE;
      o_txd <= 1'b1;
    end else begin
      if (wr_ctrl && i_wdata[`UBCE_CR_TX_EN])
        tx_on <= 1'b1;
      if (wr_ctrl && i_wdata[`UBCE_CR_TX_DIS] && tx_on)
        tx_dis_pend <= 1'b1;
      if (tx_dis_pend && !hold_full && !tx_busy) begin
        tx_on <= 1'b0;
        tx_dis_pend <= 1'b0;
      end
      // Writes while holding register full are lost
      if (i_wr && i_addr == `UBCE_THR_OFS && tx_on && !hold_full) begin
        hold_data <= i_wdata[8:0];
        hold_full <= 1'b1;
      end
      if (bit_fall) begin
        case (tx_state)
          TX_IDLE: begin
            if (hold_full) begin
              shift <= hold_data;
              hold_full <= 1'b0;
              tx_par <= (par_kind == 3'h1) ^ (^(hold_data & ~(9'h1FF << char_len)));
              tx_cnt <= 4'h0;
              o_txd <= 1'b0;
              tx_state <= TX_START;
            end
          end
          TX_START, TX_DATA: begin
            o_txd <= mode_register[`UBCE_MR_MSB] ? shift[char_len - 4'h1] : shift[0];
            shift <= mode_register[`UBCE_MR_MSB] ? (shift << 1) : (shift >> 1);
            tx_cnt <= tx_cnt + 4'h1;
            tx_state <= TX_DATA;
            if (tx_cnt + 4'h1 == char_len)
              tx_state <= (par_kind[2] && par_kind[1:0] == 2'h0) ? TX_STOP : TX_PAR;
            stop_half <= 2'h0;
          end
          TX_PAR: begin
            case (par_kind)
              3'h0, 3'h1: o_txd <= tx_par;
              3'h3: o_txd <= 1'b1;
              default: o_txd <= 1'b0;
            endcase
            tx_state <= TX_STOP;
          end
          TX_STOP: begin
            // Stop count in whole bits; the 1.5 case's bit-rise exit needs async mode, which has no bit rise, so it never fires
            o_txd <= 1'b1;
            stop_half <= stop_half + 2'h1;
            if (stop_half == 2'h0 && stop_cnt == 2'h0)
              tx_state <= TX_IDLE;
            else if (stop_half == 2'h1)
              tx_state <= TX_IDLE;
          end
          default: tx_state <= TX_IDLE;
        endcase
      end else if (bit_rise && tx_state == TX_STOP && stop_half == 2'h1 &&
                   stop_cnt == 2'h1 && async_mode) begin
        tx_state <= TX_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Asynchronous receiver
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      rx_on <= 1'b0;
      rx_dis_pend <= 1'b0;
      rx_state <= RX_HUNT;
      rx_cnt <= 4'h0;
      rx_ovs <= 4'h0;
      rx_shift <= 9'h000;
      rx_data <= 9'h000;
      rx_ready <= 1'b0;
    end else if (wr_ctrl && i_wdata[`UBCE_CR_RST_RX]) begin
      rx_on <= 1'b0;
      rx_dis_pend <= 1'b0;
      rx_state <= RX_HUNT;
      rx_ovs <= 4'h0;
      rx_ready <= 1'b0;
    end else begin
      if (wr_ctrl && i_wdata[`UBCE_CR_RX_EN])
        rx_on <= 1'b1;
      if (wr_ctrl && i_wdata[`UBCE_CR_RX_DIS])
        rx_dis_pend <= 1'b1;
      if (rx_dis_pend && rx_state == RX_HUNT) begin
        rx_on <= 1'b0;
        rx_dis_pend <= 1'b0;
      end
      // Reading the received character clears ready; a new char wins
      if (i_rd && i_addr == `UBCE_RHR_OFS)
        rx_ready <= 1'b0;
      if (sample_tick && rx_on) begin
        case (rx_state)
          RX_HUNT: begin
            if (rx_sync2) begin
              rx_ovs <= 4'h0;
            end else if (rx_ovs == (mode_register[`UBCE_MR_OVER] ? `UBCE_START_8 :
                         `UBCE_START_16)) begin
              rx_ovs <= 4'h0;
              rx_cnt <= 4'h0;
              rx_shift <= 9'h000;
              rx_state <= RX_DATA;
            end else begin
              rx_ovs <= rx_ovs + 4'h1;
            end
          end
          default: begin
            rx_ovs <= rx_ovs + 4'h1;
            if (rx_ovs == (mode_register[`UBCE_MR_OVER] ? 4'h7 : 4'hF)) begin
              rx_ovs <= 4'h0;
              case (rx_state)
                RX_DATA: begin
                  if (mode_register[`UBCE_MR_MSB])
                    rx_shift <= {rx_shift[7:0], rx_sync2};
                  else
                    rx_shift <= (rx_shift >> 1) | ({8'h00, rx_sync2} << (char_len - 4'h1));
                  rx_cnt <= rx_cnt + 4'h1;
                  if (rx_cnt + 4'h1 == char_len)
                    rx_state <= (par_kind[2] && par_kind[1:0] == 2'h0) ? RX_STOP : RX_PAR;
                end
                RX_PAR: rx_state <= RX_STOP;
                RX_STOP: begin
                  // Single stop bit, then straight back to hunting
                  rx_data <= rx_shift;
                  rx_ready <= 1'b1;
                  rx_state <= RX_HUNT;
                end
                default: rx_state <= RX_HUNT;
              endcase
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata <= 32'h00000000;
    end else begin
      o_rdata <= 32'h00000000;
      if (i_rd) begin
        case (i_addr)
          `UBCE_MODE_OFS: o_rdata <= mode_register;
          `UBCE_BRGR_OFS: o_rdata <= {16'h0000, clock_divisor};
          `UBCE_FIDI_OFS: o_rdata <= {21'h0, card_sampling_ratio};
          `UBCE_RHR_OFS: o_rdata <= {23'h0, rx_data};
          `UBCE_CSR_OFS: begin
            o_rdata[`UBCE_SR_RXRDY] <= rx_ready;
            o_rdata[`UBCE_SR_HOLD] <= tx_on & ~hold_full;
            o_rdata[`UBCE_SR_DONE] <= tx_on & ~hold_full & ~tx_busy;
          end
          default: o_rdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// >>> sim/ubce_top_monitor.sv
// Purpose: Port checker for the baud and character engine
// Assumes: Writes seen on the register port mirror the device setup
// Notes: Shadow flags only ever set, so disable commands are not tracked
`timescale 1ns/1ps
`include "ubce_defines.vh"
module ubce_top_monitor (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // Register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  // Serial pins
  input wire i_rxd,
  input wire o_txd,
  input wire i_sck,
  input wire o_sck,
  input wire o_sck_oe
);
  // ---
  // Shadow state
  // ---
  reg [31:0] mode_q;
  reg tx_on;
  reg fidi_set;
  reg div_set;
  wire rd_mode = i_rd && i_addr == `UBCE_MODE_OFS;
  wire rd_fidi = i_rd && i_addr == `UBCE_FIDI_OFS && !fidi_set;
  wire rd_off = i_rd && i_addr == `UBCE_CSR_OFS && !tx_on;
  wire rd_bad = i_rd && i_addr == 8'h30;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // Follow register writes; reset clears all
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      mode_q <= 32'h0;
      tx_on <= 1'b0;
      fidi_set <= 1'b0;
      div_set <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == `UBCE_MODE_OFS) mode_q <= i_wdata;
      if (i_addr == `UBCE_CTRL_OFS && i_wdata[`UBCE_CR_TX_EN]) tx_on <= 1'b1;
      if (i_addr == `UBCE_FIDI_OFS) fidi_set <= 1'b1;
      if (i_addr == `UBCE_BRGR_OFS) div_set <= 1'b1;
    end
  end
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_unmapped;
    $past(rd_bad) |-> o_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mode_back;
    $past(rd_mode) |-> (o_rdata & 32'h001F3FF1) == ($past(mode_q) & 32'h001F3FF1);
  endproperty
  a_mode_back: assert property (p_mode_back) else $error("mode readback wrong");
  property p_ratio_rst;
    $past(rd_fidi) |-> o_rdata[10:0] == `UBCE_FIDI_RST;
  endproperty
  a_ratio_rst: assert property (p_ratio_rst) else $error("card ratio reset wrong");
  property p_flags_off;
    $past(rd_off) |-> !o_rdata[`UBCE_SR_HOLD] && !o_rdata[`UBCE_SR_DONE];
  endproperty
  a_flags_off: assert property (p_flags_off) else $error("tx flags high while off");
  property p_txd_off;
    !tx_on |-> o_txd;
  endproperty
  a_txd_off: assert property (p_txd_off) else $error("line active before enable");
  property p_no_div;
    !div_set |-> o_txd;
  endproperty
  a_no_div: assert property (p_no_div) else $error("line active with no divisor");
  property p_start_len;
    $fell(o_txd) && !mode_q[`UBCE_MR_SYNC] |=> !o_txd [*7];
  endproperty
  a_start_len: assert property (p_start_len) else $error("async bit too short");
endmodule
bind ubce_top ubce_top_monitor mon (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(i_rxd),
  .o_txd(o_txd), .i_sck(i_sck), .o_sck(o_sck), .o_sck_oe(o_sck_oe));

// >>> sim/ubce_peer.sv
// Purpose: Remote serial peer that frames and deframes characters
// Assumes: Caller gives the bit time in clock cycles
// Notes: Receive line rests high, as a pulled-up line would
`timescale 1ns/1ps
module ubce_peer (
  // Clock
  input wire i_ref_clk,
  // Serial lines
  input wire i_txd,
  output reg o_rxd
);
  initial o_rxd = 1'b1;
  // Catch one frame; ok drops on missing start or low stop
  task get_char(input int n, input int bt, input bit msb, output logic [8:0] d,
    output bit ok);
    int i;
    begin
      d = 9'h0;
      ok = 1'b0;
      for (i = 0; i < 4000 && i_txd; i++) @(posedge i_ref_clk);
      if (!i_txd) begin
        repeat (bt / 2) @(posedge i_ref_clk);
        ok = !i_txd;
        for (i = 0; i < n; i++) begin
          repeat (bt) @(posedge i_ref_clk);
          if (msb)
            d = {d[7:0], i_txd};
          else
            d[i] = i_txd;
        end
        repeat (bt) @(posedge i_ref_clk);
        ok = ok && i_txd;
      end
    end
  endtask
  // Start, eight data bits low first, one stop
  task put_char(input logic [7:0] d, input int bt);
    int i;
    begin
      for (i = 0; i < 10; i++) begin
        o_rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i - 1];
        repeat (bt) @(posedge i_ref_clk);
      end
    end
  endtask
endmodule

// >>> sim/tb.sv
// Purpose: Self-checking bench for the baud and character engine
// Assumes: 200 MHz clock, plain register port
// Notes: Async cases use divisor 2, so a bit lasts 32 or 16 clocks
`timescale 1ns/1ps
`include "ubce_defines.vh"
module tb;
  reg i_ref_clk;
  reg i_rst;
  reg [7:0] i_addr;
  reg [31:0] i_wdata;
  reg i_wr;
  reg i_rd;
  reg i_sck;
  wire [31:0] o_rdata;
  wire o_txd;
  wire i_rxd;
  wire o_sck;
  wire o_sck_oe;
  int num_errors;
  int num_checks;
  logic [31:0] rv;
  logic [8:0] ch;
  bit ok;
  ubce_top uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(i_rxd), .o_txd(o_txd),
    .i_sck(i_sck), .o_sck(o_sck), .o_sck_oe(o_sck_oe));
  ubce_peer peer (.i_ref_clk(i_ref_clk), .i_txd(o_txd), .o_rxd(i_rxd));
  // ---
  // Clock and helpers
  // ---
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task tick;
    @(posedge i_ref_clk);
    #1;
  endtask
  task expect_tx(input int n, input bit msb, input logic [8:0] exp);
    peer.get_char(n, 32, msb, ch, ok);
    chk("frame shape", 1, ok);
    chk("tx char", exp, ch);
  endtask
  task rx_expect(input logic [7:0] exp);
    int i;
    rv = 0;
    for (i = 0; i < 200 && rv[0] !== 1'b1; i++) rd(`UBCE_CSR_OFS, rv);
    rd(`UBCE_RHR_OFS, rv);
    chk("rx char", {24'h0, exp}, rv & 32'hFF);
  endtask
  // ---
  // Scenarios
  // ---
  task t_reset;
    rd(`UBCE_FIDI_OFS, rv);
    chk("card ratio", 32'h174, rv & 32'h7FF);
    rd(`UBCE_CSR_OFS, rv);
    chk("flags at reset", 0, rv & 32'h202);
    rd(8'h30, rv);
    chk("unmapped", 0, rv);
    wr(`UBCE_THR_OFS, 32'h55); // Dropped: transmitter still off
    $display("reset test done");
  endtask
  // Plain, high-first and nine-bit characters in turn
  task t_tx;
    int k;
    wr(`UBCE_BRGR_OFS, 32'h2);
    wr(`UBCE_CTRL_OFS, 32'h40);
    for (k = 0; k < 3; k++) begin
      wr(`UBCE_MODE_OFS, 32'h08C0 | (k << 16));
      wr(`UBCE_THR_OFS, 32'h1A5);
      expect_tx(k == 2 ? 9 : 8, k == 1, k == 2 ? 9'h1A5 : 9'h0A5);
      repeat (32) @(posedge i_ref_clk);
    end
    rd(`UBCE_CSR_OFS, rv);
    chk("flags idle", 32'h202, rv & 32'h202);
    $display("tx test done");
  endtask
  // Holding full, one write lost, disable waits for both
  task t_drain;
    wr(`UBCE_MODE_OFS, 32'h08C0);
    wr(`UBCE_THR_OFS, 32'h11);
    fork
      begin
        expect_tx(8, 0, 9'h011);
        expect_tx(8, 0, 9'h022);
        peer.get_char(8, 32, 0, ch, ok);
        chk("lost char", 0, ok);
      end
      begin
        repeat (64) @(posedge i_ref_clk);
        wr(`UBCE_THR_OFS, 32'h22);
        wr(`UBCE_THR_OFS, 32'h33);
        wr(`UBCE_CTRL_OFS, 32'h80);
      end
    join
    rd(`UBCE_CSR_OFS, rv);
    chk("flags after off", 0, rv & 32'h202);
    $display("drain test done");
  endtask
  task t_soft;
    int i;
    wr(`UBCE_CTRL_OFS, 32'h40);
    wr(`UBCE_THR_OFS, 32'h00);
    for (i = 0; i < 200 && o_txd; i++) tick;
    repeat (40) tick;
    wr(`UBCE_CTRL_OFS, 32'h08);
    repeat (3) tick;
    chk("line after soft reset", 1, o_txd);
    rd(`UBCE_MODE_OFS, rv);
    chk("mode kept", 32'h08C0, rv & 32'h001F3FF1);
    $display("soft reset test done");
  endtask
  // Two back-to-back characters with one stop bit, 8x sampling
  task t_rx;
    wr(`UBCE_MODE_OFS, 32'h808C0);
    wr(`UBCE_CTRL_OFS, 32'h10);
    fork
      begin
        peer.put_char(8'h3C, 16);
        peer.put_char(8'hC3, 16);
      end
      begin
        rx_expect(8'h3C);
        rx_expect(8'hC3);
      end
    join
    $display("rx test done");
  endtask
  // Serial clock period: sync, clamped sync, clamped spi, card clock
  task t_clk;
    int k;
    int i;
    int per;
    int hi;
    for (k = 0; k < 4; k++) begin
      wr(`UBCE_BRGR_OFS, k == 0 ? 6 : k == 3 ? 8 : 1);
      wr(`UBCE_MODE_OFS, k == 3 ? 32'h140000 : k == 2 ? 32'h40101 : 32'h40100);
      per = 0;
      hi = 0;
      for (i = 0; i < 100 && o_sck !== 1'b0; i++) tick;
      for (i = 0; i < 100 && o_sck !== 1'b1; i++) tick;
      for (i = 0; i < 100 && o_sck === 1'b1; i++) begin
        tick;
        hi++;
      end
      for (i = 0; i < 100 && o_sck !== 1'b1; i++) begin
        tick;
        per++;
      end
      chk("sck period", k == 0 ? 6 : k == 3 ? 8 : k == 2 ? 6 : 3, per + hi);
      chk("sck oe", 1, o_sck_oe);
      if (k != 1) chk("sck high", (per + hi) / 2, hi);
    end
    $display("clock test done");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    i_rst = 1'b1;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_sck = 1'b0; // Pin left still, well under a third of the clock
    num_errors = 0;
    num_checks = 0;
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_reset;
    t_tx;
    t_drain;
    t_soft;
    t_rx;
    t_clk;
    close_out;
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge i_ref_clk);
    num_errors++;
    close_out;
  end
endmodule
